// File: logic/flash_unlock_map.svh
// Function
// - Key register writable, always reads zero
// - Key writes form the flash unlock sequence
// - Bulk erase ignores the target address
// - Page erase uses address to pick page
// - Row program uses address to pick row
// - Word program uses address to pick word
`ifndef FLASH_UNLOCK_MAP_SVH
`define FLASH_UNLOCK_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define FLU_KEY_OFFSET    8'h00
`define FLU_ADDR_OFFSET   8'h04
`define FLU_CTRL_OFFSET   8'h08
`define FLU_STAT_OFFSET   8'h0c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FLU_ADDR_RESET    32'h0000_0000
`define FLU_OP_RESET      2'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FLU_CTRL_OP_LSB   0
`define FLU_CTRL_START    4
`define FLU_STAT_BUSY     0
`define FLU_STAT_ARMED    1
`define FLU_STAT_DONE     2
`define FLU_STAT_REFUSED  3

// ----------------------------------------------------------------
// Unlock key values, written back to back
// ----------------------------------------------------------------
`define FLU_KEY_FIRST     32'haa99_6655
`define FLU_KEY_SECOND    32'h5566_99aa

`endif

// File: logic/flash_unlock_pkg.sv
package flash_unlock_pkg;

    // Operation selected in the control register
    typedef enum logic [1:0] {
        OP_WORD_PROGRAM = 2'h0,
        OP_ROW_PROGRAM  = 2'h1,
        OP_PAGE_ERASE   = 2'h2,
        OP_BULK_ERASE   = 2'h3
    } flash_op_e;

    // Operation sequencer states, Gray along idle-issue-wait
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'h0,
        SEQ_ISSUE = 2'h1,
        SEQ_WAIT  = 2'h3
    } seq_state_e;

    // Unlock progress states, Gray along locked-half-armed
    typedef enum logic [1:0] {
        KEY_LOCKED = 2'h0,
        KEY_HALF   = 2'h1,
        KEY_ARMED  = 2'h3
    } key_state_e;

    // Clear the low bits of an address to a block boundary
    function automatic logic [31:0] alignDown(
        input logic [31:0] addr,
        input int unsigned blockBytes
    );
        logic [31:0] mask;
        mask = ~(blockBytes[31:0] - 32'h1);
        return addr & mask;
    endfunction : alignDown

endpackage : flash_unlock_pkg

// File: logic/unlock_sequencer.sv
`timescale 1ns/1ps
`include "flash_unlock_map.svh"
module unlock_sequencer
    import flash_unlock_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        keyWrite,
    input  wire logic [31:0] keyData,
    input  wire logic        otherWrite,
    input  wire logic        startAttempt,
    output logic             armed
);

    key_state_e keyState_reg;  // Unlock progress
    key_state_e keyState_next; // Next unlock progress

    // ------------------------------------------------------------
    // Next state of the unlock sequence
    // ------------------------------------------------------------
    always_comb begin
        keyState_next = keyState_reg;
        if (startAttempt) begin
            keyState_next = KEY_LOCKED;
        end else if (otherWrite) begin
            // Any other write breaks the sequence
            keyState_next = KEY_LOCKED;
        end else if (keyWrite) begin
            case (keyState_reg)
                KEY_LOCKED: begin
                    if (keyData == `FLU_KEY_FIRST) begin
                        keyState_next = KEY_HALF;
                    end
                end
                KEY_HALF: begin
                    if (keyData == `FLU_KEY_SECOND) begin
                        keyState_next = KEY_ARMED;
                    end else if (keyData == `FLU_KEY_FIRST) begin
                        keyState_next = KEY_HALF;
                    end else begin
                        keyState_next = KEY_LOCKED;
                    end
                end
                default: begin
                    // A further key write restarts the sequence
                    if (keyData == `FLU_KEY_FIRST) begin
                        keyState_next = KEY_HALF;
                    end else begin
                        keyState_next = KEY_LOCKED;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            keyState_reg <= KEY_LOCKED;
        end else begin
            keyState_reg <= keyState_next;
        end
    end

    // Armed only after both keys in order
    assign armed = (keyState_reg == KEY_ARMED);

endmodule : unlock_sequencer

// File: logic/flash_target_decode.sv
`timescale 1ns/1ps
module flash_target_decode
    import flash_unlock_pkg::*;
#(
    parameter int unsigned PAGE_BYTES = 4096,
    parameter int unsigned ROW_BYTES  = 512,
    parameter int unsigned WORD_BYTES = 4
) (
    input  wire logic [1:0]  op,
    input  wire logic [31:0] target,
    output logic      [31:0] flashAddr
);

    // ------------------------------------------------------------
    // Elaboration checks on block sizes
    // ------------------------------------------------------------
    if ((PAGE_BYTES & (PAGE_BYTES - 1)) != 0 || PAGE_BYTES == 0) begin
        $error("PAGE_BYTES must be a power of two");
    end
    if ((ROW_BYTES & (ROW_BYTES - 1)) != 0 || ROW_BYTES > PAGE_BYTES) begin
        $error("ROW_BYTES must be a power of two within a page");
    end
    if ((WORD_BYTES & (WORD_BYTES - 1)) != 0 || WORD_BYTES == 0
        || WORD_BYTES > ROW_BYTES) begin
        $error("WORD_BYTES must be a power of two within a row");
    end

    // ------------------------------------------------------------
    // Address handed to the array for each operation
    // ------------------------------------------------------------
    always_comb begin
        case (flash_op_e'(op))
            OP_PAGE_ERASE: begin
                flashAddr = alignDown(target, PAGE_BYTES);
            end
            OP_ROW_PROGRAM: begin
                flashAddr = alignDown(target, ROW_BYTES);
            end
            OP_WORD_PROGRAM: begin
                flashAddr = alignDown(target, WORD_BYTES);
            end
            default: begin
                // Whole array: target is not looked at
                flashAddr = 32'h0000_0000;
            end
        endcase
    end

endmodule : flash_target_decode

// File: logic/flash_unlock_and_address_regs.sv
`timescale 1ns/1ps
`include "flash_unlock_map.svh"
module flash_unlock_and_address_regs
    import flash_unlock_pkg::*;
#(
    parameter int unsigned PAGE_BYTES = 4096,
    parameter int unsigned ROW_BYTES  = 512,
    parameter int unsigned WORD_BYTES = 4
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdata,
    output logic             flashStart,
    output logic      [1:0]  flashOp,
    output logic      [31:0] flashAddr,
    input  wire logic        flashDone
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [31:0] target_reg;     // Target address register
    logic [1:0]  op_reg;         // Selected operation
    logic        done_reg;       // Sticky: operation finished
    logic        refused_reg;    // Sticky: start was refused
    logic [31:0] rdata_reg;      // Read data, one cycle late
    logic [1:0]  flashOp_reg;    // Operation held for the array
    logic [31:0] flashAddr_reg;  // Address held for the array
    seq_state_e  state_reg;      // Operation sequencer state
    seq_state_e  state_next;     // Next sequencer state

    logic        keyWrite;       // Write to the key register
    logic        addrWrite;      // Write to the target address
    logic        ctrlWrite;      // Write to the control register
    logic        statWrite;      // Write to the status register
    logic        otherWrite;     // Write other than the key or a start
    logic        startAttempt;   // Control write with start set
    logic        armed;          // Unlock sequence complete
    logic        busy;           // Operation in progress
    logic        startOk;        // Start accepted this cycle
    logic        refuseNow;      // Start refused this cycle
    logic        doneNow;        // Array reports completion
    logic [31:0] decodedAddr;    // Address chosen for the op
    logic [31:0] readMux;        // Read data before the flop

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    always_comb begin
        keyWrite  = 1'b0;
        addrWrite = 1'b0;
        ctrlWrite = 1'b0;
        statWrite = 1'b0;
        if (!regWrite) begin
            // No write this cycle
        end else if (regAddr == `FLU_KEY_OFFSET) begin
            keyWrite = 1'b1;
        end else if (regAddr == `FLU_ADDR_OFFSET) begin
            addrWrite = 1'b1;
        end else if (regAddr == `FLU_CTRL_OFFSET) begin
            ctrlWrite = 1'b1;
        end else if (regAddr == `FLU_STAT_OFFSET) begin
            statWrite = 1'b1;
        end else begin
            // Unmapped write: dropped
        end
    end

    // Start request carried by a control write
    assign startAttempt = ctrlWrite && regWdata[`FLU_CTRL_START];

    // Writes that break an unlock in progress
    assign otherWrite = regWrite && !keyWrite && !startAttempt;

    // ------------------------------------------------------------
    // Unlock sequence tracker
    // ------------------------------------------------------------
    unlock_sequencer u_unlock (
        .clk          (clk),
        .reset        (reset),
        .keyWrite     (keyWrite),
        .keyData      (regWdata),
        .otherWrite   (otherWrite),
        .startAttempt (startAttempt),
        .armed        (armed)
    );

    // ------------------------------------------------------------
    // Start acceptance
    // ------------------------------------------------------------
    assign busy      = (state_reg != SEQ_IDLE);
    assign startOk   = startAttempt && armed && !busy;
    assign refuseNow = startAttempt && !startOk;
    assign doneNow   = (state_reg == SEQ_WAIT) && flashDone;

    // ------------------------------------------------------------
    // Target address register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            target_reg <= `FLU_ADDR_RESET;
        end else if (addrWrite && !busy) begin
            // Held steady while an operation runs
            target_reg <= regWdata;
        end
    end

    // ------------------------------------------------------------
    // Operation select in the control register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            op_reg <= `FLU_OP_RESET;
        end else if (ctrlWrite && !busy) begin
            op_reg <= regWdata[`FLU_CTRL_OP_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Address decode per operation
    // ------------------------------------------------------------
    flash_target_decode #(
        .PAGE_BYTES (PAGE_BYTES),
        .ROW_BYTES  (ROW_BYTES),
        .WORD_BYTES (WORD_BYTES)
    ) u_decode (
        .op        (ctrlWrite ? regWdata[`FLU_CTRL_OP_LSB +: 2]
                              : op_reg),
        .target    (target_reg),
        .flashAddr (decodedAddr)
    );

    // ------------------------------------------------------------
    // Operation sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SEQ_IDLE: begin
                if (startOk) begin
                    state_next = SEQ_ISSUE;
                end
            end
            SEQ_ISSUE: begin
                // One cycle of start toward the array
                state_next = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (flashDone) begin
                    state_next = SEQ_IDLE;
                end
            end
            default: begin
                state_next = SEQ_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Operation sequencer state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= SEQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Operation and address captured at an accepted start
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            flashOp_reg   <= `FLU_OP_RESET;
            flashAddr_reg <= `FLU_ADDR_RESET;
        end else if (startOk) begin
            flashOp_reg   <= ctrlWrite ? regWdata[`FLU_CTRL_OP_LSB +: 2]
                                       : op_reg;
            flashAddr_reg <= decodedAddr;
        end
    end

    // ------------------------------------------------------------
    // Sticky completion flag, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            done_reg <= 1'b0;
        end else if (doneNow) begin
            done_reg <= 1'b1;
        end else if (statWrite && regWdata[`FLU_STAT_DONE]) begin
            done_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sticky refusal flag, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            refused_reg <= 1'b0;
        end else if (refuseNow) begin
            refused_reg <= 1'b1;
        end else if (statWrite && regWdata[`FLU_STAT_REFUSED]) begin
            refused_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read data select
    // ------------------------------------------------------------
    always_comb begin
        readMux = 32'h0000_0000;
        if (regAddr == `FLU_KEY_OFFSET) begin
            // Key contents never leave the block
            readMux = 32'h0000_0000;
        end else if (regAddr == `FLU_ADDR_OFFSET) begin
            readMux = target_reg;
        end else if (regAddr == `FLU_CTRL_OFFSET) begin
            readMux[`FLU_CTRL_OP_LSB +: 2] = op_reg;
        end else if (regAddr == `FLU_STAT_OFFSET) begin
            readMux[`FLU_STAT_BUSY]    = busy;
            readMux[`FLU_STAT_ARMED]   = armed;
            readMux[`FLU_STAT_DONE]    = done_reg;
            readMux[`FLU_STAT_REFUSED] = refused_reg;
        end else begin
            // Unmapped: reads zero
            readMux = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Read data register, valid the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 32'h0000_0000;
        end else if (regRead) begin
            rdata_reg <= readMux;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regRdata   = rdata_reg;
    assign flashStart = (state_reg == SEQ_ISSUE);
    assign flashOp    = flashOp_reg;
    assign flashAddr  = flashAddr_reg;

endmodule : flash_unlock_and_address_regs

// File: sim/flash_unlock_and_address_regs_sva.sv
`timescale 1ns/1ps
`include "flash_unlock_map.svh"
module flash_unlock_and_address_regs_sva
    import flash_unlock_pkg::*;
#(
    parameter int unsigned PAGE_BYTES = 4096,
    parameter int unsigned ROW_BYTES  = 512,
    parameter int unsigned WORD_BYTES = 4
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        flashStart,
    input wire logic [1:0]  flashOp,
    input wire logic [31:0] flashAddr,
    input wire logic        flashDone
);
    // ------------------------------------------------------------
    // Shadow state: unlock progress, busy, target register
    // ------------------------------------------------------------
    logic        half;   // Last write was the first key
    logic        ok;     // Last two writes were first then second key
    logic        busy;   // Operation in flight
    logic [31:0] tgt;    // Target address as software left it

    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Follow writes the same way software sees them
    always_ff @(posedge clk) begin
        if (reset) begin
            half <= 1'b0;
            ok   <= 1'b0;
            busy <= 1'b0;
            tgt  <= 32'h0;
        end else begin
            if (regWrite) begin
                half <= regAddr == `FLU_KEY_OFFSET
                        && regWdata == `FLU_KEY_FIRST;
                ok   <= half && regAddr == `FLU_KEY_OFFSET
                        && regWdata == `FLU_KEY_SECOND;
            end
            if (regWrite && regAddr == `FLU_ADDR_OFFSET && !busy
                && !flashStart)
                tgt <= regWdata;
            if (flashStart)
                busy <= 1'b1;
            else if (flashDone)
                busy <= 1'b0;
        end
    end

    AST_KEY_READS_ZERO: assert property (
        regRead && regAddr == `FLU_KEY_OFFSET |=> regRdata == 32'h0)
        else $error("key register read returned nonzero");
    AST_RDATA_ONE_CYCLE: assert property (
        !regRead |=> regRdata == 32'h0)
        else $error("read data present without a read");
    AST_START_NEEDS_UNLOCK: assert property (
        flashStart |-> $past(ok) && $past(regWrite)
        && $past(regAddr) == `FLU_CTRL_OFFSET && $past(regWdata[4]))
        else $error("start issued without fresh unlock");
    AST_START_PULSE: assert property (
        flashStart |=> !flashStart)
        else $error("start pulse longer than one cycle");
    AST_BULK_IGNORES: assert property (
        flashStart && flashOp == OP_BULK_ERASE |-> flashAddr == 32'h0)
        else $error("bulk erase passed a target address");
    AST_PAGE_PICK: assert property (
        flashStart && flashOp == OP_PAGE_ERASE
        |-> flashAddr == (tgt & ~(32'(PAGE_BYTES) - 32'h1)))
        else $error("page erase address wrong");
    AST_ROW_PICK: assert property (
        flashStart && flashOp == OP_ROW_PROGRAM
        |-> flashAddr == (tgt & ~(32'(ROW_BYTES) - 32'h1)))
        else $error("row program address wrong");
    AST_WORD_PICK: assert property (
        flashStart && flashOp == OP_WORD_PROGRAM
        |-> flashAddr == (tgt & ~(32'(WORD_BYTES) - 32'h1)))
        else $error("word program address wrong");
    AST_OP_FROM_WRITE: assert property (
        flashStart |-> flashOp == $past(regWdata[1:0]))
        else $error("operation differs from control write");
    AST_ADDR_HELD: assert property (
        !flashStart |-> $stable(flashAddr) && $stable(flashOp))
        else $error("array address changed between starts");

    // Main scenarios reached
    cover property (flashStart && flashOp == OP_BULK_ERASE);
    cover property (flashStart && flashOp == OP_PAGE_ERASE);
    cover property (regRead && regAddr == `FLU_KEY_OFFSET);
endmodule : flash_unlock_and_address_regs_sva

// File: sim/flash_unlock_and_address_regs_bench.sv
`timescale 1ns/1ps
`include "flash_unlock_map.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module flash_unlock_and_address_regs_bench
    import flash_unlock_pkg::*;
;
    localparam int unsigned PG = 4096;
    localparam int unsigned RW = 512;
    localparam int unsigned WB = 4;
    logic        clk, reset, regWrite, regRead, flashStart;
    logic        flashDone = 1'b0;    // Driven only by the array side
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, flashAddr, tgtM;
    logic [1:0]  flashOp, opM;
    logic        busyM, doneM, refM;  // Model status flags
    int          arm, mismatches, tests_run, doneDelay;
    logic [33:0] expQ[$];             // Expected {op, address} per start

    flash_unlock_and_address_regs #(
        .PAGE_BYTES(PG), .ROW_BYTES(RW), .WORD_BYTES(WB)
    ) u_dut (
        .clk(clk), .reset(reset), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .flashStart(flashStart),
        .flashOp(flashOp), .flashAddr(flashAddr), .flashDone(flashDone)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Behavioural model
    // ------------------------------------------------------------
    task automatic mreset();
        arm = 0;
        tgtM = 32'h0;
        opM = 2'h0;
        busyM = 1'b0;
        doneM = 1'b0;
        refM = 1'b0;
    endtask : mreset

    function automatic logic [31:0] align(logic [1:0] op);
        case (op)
            2'h3: return 32'h0;
            2'h2: return tgtM & ~(PG - 1);
            2'h1: return tgtM & ~(RW - 1);
            default: return tgtM & ~(WB - 1);
        endcase
    endfunction : align

    task automatic model(logic [7:0] a, logic [31:0] d);
        case (a)
            `FLU_KEY_OFFSET: arm = (d == `FLU_KEY_FIRST) ? 1 :
                (arm == 1 && d == `FLU_KEY_SECOND) ? 2 : 0;
            `FLU_ADDR_OFFSET: if (!busyM) tgtM = d;
            `FLU_CTRL_OFFSET: begin
                if (!busyM) opM = d[1:0];
                if (d[4] && arm == 2 && !busyM) begin
                    busyM = 1'b1;
                    expQ.push_back({d[1:0], align(d[1:0])});
                end else if (d[4]) refM = 1'b1;
            end
            `FLU_STAT_OFFSET: begin
                if (d[2]) doneM = 1'b0;
                if (d[3]) refM = 1'b0;
            end
            default: ;
        endcase
        if (a != `FLU_KEY_OFFSET) arm = 0;
    endtask : model

    // ------------------------------------------------------------
    // Register bus tasks
    // ------------------------------------------------------------
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
        model(a, d);
    endtask : wr

    task automatic rd(logic [7:0] a);
        logic [31:0] e;
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        case (a)
            `FLU_ADDR_OFFSET: e = tgtM;
            `FLU_CTRL_OFFSET: e = {30'h0, opM};
            `FLU_STAT_OFFSET: e = {28'h0, refM, doneM, arm == 2, busyM};
            default: e = 32'h0;
        endcase
        `CHK("regRdata", e, regRdata)
    endtask : rd

    task automatic unlock();
        wr(`FLU_KEY_OFFSET, `FLU_KEY_FIRST);
        wr(`FLU_KEY_OFFSET, `FLU_KEY_SECOND);
    endtask : unlock

    task automatic start(logic [1:0] op);
        wr(`FLU_CTRL_OFFSET, {27'h0, 1'b1, 2'h0, op});
    endtask : start

    task automatic waitIdle();
        for (int n = 0; n < 300 && busyM; n++) @(posedge clk);
        `CHK("idle", 1'b0, busyM)
    endtask : waitIdle

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Check every start pulse against the model
    always @(posedge clk) begin
        logic [33:0] got, e;
        if (flashStart === 1'b1) begin
            got = {flashOp, flashAddr};
            #2;
            e = (expQ.size() != 0) ? expQ.pop_front() : '1;
            `CHK("flash op and address", e, got)
        end
    end

    // Array side answers each start after doneDelay cycles
    always @(posedge clk) begin
        if (flashStart === 1'b1) begin
            repeat (doneDelay) @(posedge clk);
            flashDone <= 1'b1;
            @(posedge clk);
            flashDone <= 1'b0;
            #2;
            busyM = 1'b0;
            doneM = 1'b1;
        end
    end

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        {regAddr, regWdata, regWrite, regRead} = '0;
        reset = 1'b1;
        mismatches = 0;
        tests_run = 0;
        doneDelay = 4;
        mreset();
        void'($urandom(32'h5c23));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 24; a += 4) rd(8'(a));
        wr(`FLU_KEY_OFFSET, $urandom);
        rd(`FLU_KEY_OFFSET);
        for (int op = 0; op < 4; op++) begin
            wr(`FLU_ADDR_OFFSET, $urandom);
            unlock();
            rd(`FLU_STAT_OFFSET);
            start(2'(op));
            waitIdle();
            rd(`FLU_STAT_OFFSET);
            wr(`FLU_STAT_OFFSET, 32'hc);
            rd(`FLU_STAT_OFFSET);
        end
        start(2'h3);
        wr(`FLU_KEY_OFFSET, `FLU_KEY_FIRST);
        wr(`FLU_KEY_OFFSET, 32'h0);
        wr(`FLU_KEY_OFFSET, `FLU_KEY_SECOND);
        start(2'h0);
        unlock();
        wr(`FLU_ADDR_OFFSET, $urandom);
        start(2'h1);
        wr(`FLU_KEY_OFFSET, `FLU_KEY_SECOND);
        wr(`FLU_KEY_OFFSET, `FLU_KEY_FIRST);
        start(2'h1);
        rd(`FLU_STAT_OFFSET);
        wr(`FLU_KEY_OFFSET, `FLU_KEY_FIRST);
        unlock();
        start(2'h2);
        start(2'h2);
        waitIdle();
        doneDelay = 40;
        unlock();
        start(2'h2);
        wr(`FLU_ADDR_OFFSET, $urandom);
        wr(`FLU_CTRL_OFFSET, 32'h1);
        unlock();
        start(2'h0);
        rd(`FLU_STAT_OFFSET);
        rd(`FLU_ADDR_OFFSET);
        rd(`FLU_CTRL_OFFSET);
        waitIdle();
        rd(`FLU_STAT_OFFSET);
        repeat (400) begin
            doneDelay = 1 + $urandom % 12;
            case ($urandom % 8)
                0: wr(`FLU_KEY_OFFSET, `FLU_KEY_FIRST);
                1: wr(`FLU_KEY_OFFSET, `FLU_KEY_SECOND);
                2: begin
                    unlock();
                    start(2'($urandom));
                end
                3: wr({3'h0, 3'($urandom % 6), 2'h0}, $urandom);
                4: wr(`FLU_CTRL_OFFSET, $urandom & 32'h13);
                5: wr(`FLU_STAT_OFFSET, $urandom);
                default: rd({3'h0, 3'($urandom % 6), 2'h0});
            endcase
        end
        waitIdle();
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        mreset();
        rd(`FLU_ADDR_OFFSET);
        rd(`FLU_STAT_OFFSET);
        `CHK("pending starts", 0, expQ.size())
        summarize();
    end
endmodule : flash_unlock_and_address_regs_bench

bind flash_unlock_and_address_regs flash_unlock_and_address_regs_sva #(
    .PAGE_BYTES(PAGE_BYTES), .ROW_BYTES(ROW_BYTES),
    .WORD_BYTES(WORD_BYTES)
) u_sva (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .flashStart(flashStart), .flashOp(flashOp),
    .flashAddr(flashAddr), .flashDone(flashDone)
);
